// ===== rtl/lbi_pkg.sv
// Function
// - Fade-on code 0011 in the upper nibble gives a 192 ms upward ramp.
// - Fully-on code 0101 in the upper nibble holds outputs on 384 ms.
// - First fully-off code 0110 in the upper nibble holds outputs off 512 ms.
// - Fade-off code 0011 in the upper nibble gives a 192 ms downward ramp.
// - Peak register: upper nibble drives upper dimmer, lower nibble lower dimmer.
// - Peak register is the auto-increment destination after second fully-off time.
// - Both peak codes reset to 1111, full brightness.
// - Brightness is set by low-time duty within a fixed 8 ms period.
// - Writing 1111 0000 to the peak register gives the upper group full intensity.
// - Writing 0111 0000 to the peak register gives the upper group half intensity.
// - Low share of each period equals brightness; 25% is 2 ms low, 6 ms released.
// - 12.5% is 1 ms low of 8 ms; 37.5% is 3 ms low of 8 ms.
// - Output i state comes from bit i of the three state planes.
// - Timing codes reset to 4 (256 ms); code 15 means 16320 ms.
// - With auto-increment, low four pointer bits step after each stored byte.
package lbi_pkg;

	// Register pointers in auto-increment order.
	localparam logic [3:0] ADDR_PLANE_A   = 4'h0;
	localparam logic [3:0] ADDR_PLANE_B   = 4'h1;
	localparam logic [3:0] ADDR_PLANE_C   = 4'h2;
	localparam logic [3:0] ADDR_FADE_ON   = 4'h3;
	localparam logic [3:0] ADDR_FULL_ON   = 4'h4;
	localparam logic [3:0] ADDR_FADE_OFF  = 4'h5;
	localparam logic [3:0] ADDR_FIRST_OFF = 4'h6;
	localparam logic [3:0] ADDR_SECOND_OFF = 4'h7;
	localparam logic [3:0] ADDR_PEAK      = 4'h8;

	// Command byte fields.
	localparam int CMD_AI_BIT = 4;

	// Nibble positions of the two channel groups.
	localparam int UPPER_LSB = 4;
	localparam int LOWER_LSB = 0;

	// Reset values.
	localparam logic [7:0] RST_PLANE = 8'h00;
	localparam logic [7:0] RST_TIME  = 8'h44;
	localparam logic [7:0] RST_PEAK  = 8'hff;

	// Timing, at a 125 MHz clock.
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_NS         = 1000000;
	localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
	localparam int PWM_PERIOD_MS = 8;
	localparam int PWM_SLOTS     = 16;
	localparam int SLOT_NS       = PWM_PERIOD_MS * MS_NS / PWM_SLOTS;
	localparam int SLOT_CYC      = SLOT_NS / CLK_PERIOD_NS;

	// Register write strobes from the serial slave.
	typedef struct packed {
		logic       cmd_valid;
		logic       data_valid;
		logic [7:0] wbyte;
	} lbi_wr_t;

	typedef enum logic [1:0] {PH_FADE_ON, PH_ON, PH_FADE_OFF, PH_OFF} lbi_phase_t;

	typedef struct packed {
		lbi_phase_t  phase;
		logic [13:0] elapsed;
		logic        use_second;
	} lbi_bank_t;

	// Blink timing code to milliseconds.
	// code to time
	function automatic logic [13:0] lbi_code_ms(input logic [3:0] code);
		case (code)
			4'h0:    lbi_code_ms = 14'h0000;
			4'h1:    lbi_code_ms = 14'h0040;
			4'h2:    lbi_code_ms = 14'h0080;
			4'h3:    lbi_code_ms = 14'h00c0;
			4'h4:    lbi_code_ms = 14'h0100;
			4'h5:    lbi_code_ms = 14'h0180;
			4'h6:    lbi_code_ms = 14'h0200;
			4'h7:    lbi_code_ms = 14'h0300;
			4'h8:    lbi_code_ms = 14'h0400;
			4'h9:    lbi_code_ms = 14'h0600;
			4'ha:    lbi_code_ms = 14'h0800;
			4'hb:    lbi_code_ms = 14'h0c00;
			4'hc:    lbi_code_ms = 14'h1000;
			4'hd:    lbi_code_ms = 14'h1680;
			4'he:    lbi_code_ms = 14'h1fc0;
			default: lbi_code_ms = 14'h3fc0;
		endcase
	endfunction

	// Nibble of a register belonging to a group (1 upper, 0 lower).
	// group nibble select
	function automatic logic [3:0] lbi_nib(input logic [7:0] r, input logic grp);
		lbi_nib = grp ? r[UPPER_LSB +: 4] : r[LOWER_LSB +: 4];
	endfunction

endpackage

// ===== rtl/lbi_top.sv
`timescale 1ns/1ps
module lbi_top
	import lbi_pkg::*;
#(
	parameter int CYC_MS  = CYC_PER_MS,
	parameter int CYC_SLT = SLOT_CYC
) (
	input  wire logic          clk,               // 125 MHz clock.
	input  wire logic          nrst,              // Asynchronous reset, active low.
	input  wire lbi_wr_t       wr,                // Command and data byte strobes.
	output logic [6:0]         led_output_line_o, // Pin level when driven, always low.
	output logic [6:0]         led_output_line_oe,// High while the pin is pulled low.
	output lbi_phase_t [1:0]   bank_phase         // Phase of upper [1] and lower [0] group.
);

	typedef struct packed {
		logic [8:0][7:0] regs;
		logic [3:0]      ptr;
		logic            ai;
		logic [16:0]     presc;
		logic [19:0]     slot_cnt;
		logic [3:0]      slot;
		lbi_bank_t [1:0] bank;
		logic [6:0]      led_low;
		logic [6:0]      led_lvl;
	} lbi_state_t;

	lbi_state_t q;
	lbi_state_t d;
	logic [1:0] rsync_q;
	logic       rst_n;

	// Reset is released through two flops so every flop leaves reset on the same edge.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rsync_q <= 2'h0;
		end else begin
			rsync_q <= {rsync_q[0], 1'b1};
		end
	end
	assign rst_n = rsync_q[1];

	// Duration of the active phase for a group.
	// phase time select
	function automatic logic [13:0] phase_ms(input lbi_state_t s, input logic g);
		logic [7:0] r;
		r = s.regs[ADDR_FADE_ON];
		case (s.bank[g].phase)
			PH_FADE_ON:  r = s.regs[ADDR_FADE_ON];
			PH_ON:       r = s.regs[ADDR_FULL_ON];
			PH_FADE_OFF: r = s.regs[ADDR_FADE_OFF];
			PH_OFF:      r = s.bank[g].use_second ? s.regs[ADDR_SECOND_OFF]
			                                      : s.regs[ADDR_FIRST_OFF];
			default:     r = s.regs[ADDR_FADE_ON];
		endcase
		phase_ms = lbi_code_ms(lbi_nib(r, g));
	endfunction

	// Steady dimmer: low while the slot is below peak+1 of sixteen.
	// duty from peak
	function automatic logic steady_low(input lbi_state_t s, input logic g);
		steady_low = {1'b0, s.slot} < ({1'b0, lbi_nib(s.regs[ADDR_PEAK], g)} + 5'h01);
	endfunction

	// Blinking group: fade-on scales the peak duty by elapsed over duration, fade-off by remaining time over duration.
	function automatic logic blink_low(input lbi_state_t s, input logic g);
		logic [13:0] dur;
		logic [19:0] lhs;
		logic [19:0] pk;
		dur = phase_ms(s, g);
		lhs = 20'(s.slot) * 20'(dur);
		pk  = 20'(lbi_nib(s.regs[ADDR_PEAK], g)) + 20'h1;
		case (s.bank[g].phase)
			PH_FADE_ON:  blink_low = lhs < pk * 20'(s.bank[g].elapsed);
			PH_ON:       blink_low = steady_low(s, g);
			PH_FADE_OFF: blink_low = lhs < pk * 20'(dur - s.bank[g].elapsed);
			default:     blink_low = 1'b0;
		endcase
	endfunction

	// Next-state logic for the whole block.
	always_comb begin
		logic       ms_tick;
		logic [2:0] sel;
		logic [13:0] dur;
		ms_tick = 1'b0;
		sel     = 3'h0;
		dur     = 14'h0000;
		d       = q;
		// Millisecond tick for the blink sequencers.
		if (q.presc == 17'(CYC_MS - 1)) begin
			d.presc = 17'h00000;
			ms_tick = 1'b1;
		end else begin
			d.presc = q.presc + 17'h00001;
		end
		// fixed PWM period
		// Sixteen slots of half a millisecond make up the 8 ms period.
		if (q.slot_cnt == 20'(CYC_SLT - 1)) begin
			d.slot_cnt = 20'h00000;
			d.slot     = q.slot + 4'h1;
		end else begin
			d.slot_cnt = q.slot_cnt + 20'h00001;
		end
		// pointer auto-increment
		// A command loads the pointer; each data byte stores (pointer up to 8) and, with auto-increment set, then steps it.
		if (wr.cmd_valid) begin
			d.ptr = wr.wbyte[3:0];
			d.ai  = wr.wbyte[CMD_AI_BIT];
		end else if (wr.data_valid) begin
			if (q.ptr <= ADDR_PEAK) begin
				d.regs[q.ptr] = wr.wbyte;
			end
			if (q.ai) begin
				d.ptr = q.ptr + 4'h1;
			end
		end
		// phase sequencer
		// Zero-length phases still last one tick, which keeps the sequencer simple.
		for (int g = 0; g < 2; g++) begin
			dur = phase_ms(q, g[0]);
			if (ms_tick) begin
				if (14'(q.bank[g].elapsed + 14'h0001) >= dur) begin
					d.bank[g].elapsed = 14'h0000;
					case (q.bank[g].phase)
						PH_FADE_ON:  d.bank[g].phase = PH_ON;
						PH_ON:       d.bank[g].phase = PH_FADE_OFF;
						PH_FADE_OFF: d.bank[g].phase = PH_OFF;
						PH_OFF: begin
							d.bank[g].phase      = PH_FADE_ON;
							d.bank[g].use_second = ~q.bank[g].use_second;
						end
						default:     d.bank[g].phase = PH_FADE_ON;
					endcase
				end else begin
					d.bank[g].elapsed = q.bank[g].elapsed + 14'h0001;
				end
			end
		end
		// plane decode
		// Each output takes its state from the same bit of the three planes.
		for (int i = 0; i < 7; i++) begin
			sel = {q.regs[ADDR_PLANE_C][i], q.regs[ADDR_PLANE_B][i], q.regs[ADDR_PLANE_A][i]};
			case (sel)
				3'h2:    d.led_low[i] = steady_low(q, 1'b0);
				3'h3:    d.led_low[i] = steady_low(q, 1'b1);
				3'h4,
				3'h5:    d.led_low[i] = 1'b1;
				3'h6:    d.led_low[i] = blink_low(q, 1'b0);
				3'h7:    d.led_low[i] = blink_low(q, 1'b1);
				default: d.led_low[i] = 1'b0;
			endcase
		end
		d.led_lvl = 7'h00;
	end

	// State register; the time registers come up at 256 ms, peak at full scale.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.regs[ADDR_PLANE_A]    <= RST_PLANE;
			q.regs[ADDR_PLANE_B]    <= RST_PLANE;
			q.regs[ADDR_PLANE_C]    <= RST_PLANE;
			q.regs[ADDR_FADE_ON]    <= RST_TIME;
			q.regs[ADDR_FULL_ON]    <= RST_TIME;
			q.regs[ADDR_FADE_OFF]   <= RST_TIME;
			q.regs[ADDR_FIRST_OFF]  <= RST_TIME;
			q.regs[ADDR_SECOND_OFF] <= RST_TIME;
			q.regs[ADDR_PEAK]       <= RST_PEAK;
		end else begin
			q <= d;
		end
	end

	// Open-drain outputs come straight from the state register.
	assign led_output_line_o  = q.led_lvl;
	assign led_output_line_oe = q.led_low;
	assign bank_phase[1]      = q.bank[1].phase;
	assign bank_phase[0]      = q.bank[0].phase;

	AST_PEAK_RESET: assert property (@(posedge clk) $rose(rst_n) |->
		q.regs[ADDR_PEAK] == RST_PEAK) else $error("Peak code not full after reset.");

	AST_TIME_RESET: assert property (@(posedge clk) $rose(rst_n) |->
		q.regs[ADDR_FADE_ON] == RST_TIME && q.regs[ADDR_SECOND_OFF] == RST_TIME
		&& lbi_code_ms(lbi_nib(q.regs[ADDR_FULL_ON], 1'b1)) == 14'h0100)
		else $error("Timing code not 256 ms after reset.");

	AST_AUTO_INC: assert property (@(posedge clk) disable iff (!rst_n)
		wr.data_valid && !wr.cmd_valid && q.ai |=> q.ptr == 4'($past(q.ptr) + 4'h1))
		else $error("Pointer did not step after data byte.");

	AST_PEAK_STORE: assert property (@(posedge clk) disable iff (!rst_n)
		wr.data_valid && !wr.cmd_valid && q.ptr == ADDR_SECOND_OFF && q.ai
		##1 wr.data_valid && !wr.cmd_valid |=> q.regs[ADDR_PEAK] == $past(wr.wbyte))
		else $error("Byte after second off time did not reach peak register.");

	AST_FULL_LOW: assert property (@(posedge clk) disable iff (!rst_n)
		q.regs[ADDR_PEAK][7:4] == 4'hf && q.regs[ADDR_PLANE_A][0] && q.regs[ADDR_PLANE_B][0]
		&& !q.regs[ADDR_PLANE_C][0] && !wr.data_valid |=> q.led_low[0])
		else $error("Full upper peak did not hold output low.");

	AST_HALF_DUTY: assert property (@(posedge clk) disable iff (!rst_n)
		q.regs[ADDR_PEAK][7:4] == 4'h7 && q.regs[ADDR_PLANE_A][0] && q.regs[ADDR_PLANE_B][0]
		&& !q.regs[ADDR_PLANE_C][0] && !wr.data_valid |=> q.led_low[0] == ($past(q.slot) < 4'h8))
		else $error("Half peak duty wrong.");

	AST_QUARTER_DUTY: assert property (@(posedge clk) disable iff (!rst_n)
		q.regs[ADDR_PEAK][7:4] == 4'h3 && q.regs[ADDR_PLANE_A][0] && q.regs[ADDR_PLANE_B][0]
		&& !q.regs[ADDR_PLANE_C][0] |=> q.led_low[0] == ($past(q.slot) < 4'h4))
		else $error("Quarter peak duty wrong.");

	AST_OFF_STATE: assert property (@(posedge clk) disable iff (!rst_n)
		!q.regs[ADDR_PLANE_B][3] && !q.regs[ADDR_PLANE_C][3] && !wr.data_valid |=> !q.led_low[3])
		else $error("Output driven while planes select off.");

	AST_PHASE_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
		q.bank[1].phase != $past(q.bank[1].phase) && $past(q.bank[1].phase) == PH_FADE_ON
		|-> q.bank[1].phase == PH_ON) else $error("Fade-on not followed by fully-on.");

	AST_BLINK_OFF: assert property (@(posedge clk) disable iff (!rst_n)
		q.bank[1].phase == PH_OFF && q.regs[ADDR_PLANE_C][1] && q.regs[ADDR_PLANE_A][1]
		&& q.regs[ADDR_PLANE_B][1] && !wr.data_valid ##1 q.bank[1].phase == PH_OFF
		|-> !q.led_low[1]) else $error("Blinking output low during off phase.");

endmodule

// ===== test/lbi_host_model.sv
`timescale 1ns/1ps
module lbi_host_model
	import lbi_pkg::*;
(
	input  wire logic clk, // Clock shared with the block.
	output lbi_wr_t   wr   // Command and data strobes towards the block.
);
	// The strobes start idle so nothing is taken during reset.
	initial begin
		wr = '0;
	end

	// Drive one byte for one cycle; data goes to the pointer set by the last command.
	task automatic send(input logic c, input logic [7:0] b);
		@(posedge clk);
		wr <= '{cmd_valid: c, data_valid: !c, wbyte: b};
	endtask

	// command then bytes
	// One command followed by back to back data bytes, then the bus is let go.
	task automatic burst(input logic [7:0] cmd, input logic [7:0] d[$]);
		send(1'b1, cmd);
		foreach (d[i]) begin
			send(1'b0, d[i]);
		end
		@(posedge clk);
		// A released byte shows the inverse of the last value, so stale data cannot pass.
		wr <= '{cmd_valid: 1'b0, data_valid: 1'b0, wbyte: ~wr.wbyte};
	endtask
endmodule

// ===== test/lbi_top_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
	$display("unexpected %s expected %0d seen %0d", nm, e, g); end end
module lbi_top_bench;
	import lbi_pkg::*;
	localparam int MS  = 16;
	localparam int SLT = 4;
	localparam int PER = 16 * SLT;
	logic             clk = 1'b0;
	logic             nrst = 1'b0;
	lbi_wr_t          wr;
	logic [6:0]       oe;
	logic [6:0]       lvl;
	lbi_phase_t [1:0] ph;
	int               mismatches = 0;
	int               samples_checked = 0;
	int               cycles = 0;

	lbi_host_model u_host (.clk(clk), .wr(wr));
	lbi_top #(.CYC_MS(MS), .CYC_SLT(SLT)) u_lbi_top (.clk(clk), .nrst(nrst), .wr(wr),
		.led_output_line_o(lvl), .led_output_line_oe(oe), .bank_phase(ph));

	// Free running clock at 125 MHz.
	initial begin
		forever #4 clk = ~clk;
	end

	// A hang is cut short long after the blink test should have ended.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Counts driven-low cycles of one output over one whole dimmer period.
	task automatic low_count(input int b, output logic [31:0] n);
		n = 0;
		repeat (PER) begin
			@(negedge clk);
			n += oe[b];
		end
	endtask

	// Counts the cycles the upper group spends in the next occurrence of a phase.
	task automatic phase_len(input lbi_phase_t p, output logic [31:0] n);
		n = 0;
		while (ph[1] !== p) @(negedge clk);
		while (ph[1] === p) begin
			n++;
			@(negedge clk);
		end
	endtask

	// Output 0 steady at the upper peak, output 6 steady at the lower peak.
	task automatic t_reset();
		logic [31:0] n;
		for (int b = 0; b < 7; b++) begin
			low_count(b, n);
			`CHK("dark after reset", 32'd0, n)
		end
		`CHK("pin level", 7'h00, lvl)
		u_host.burst(8'h10, '{8'h01, 8'h41});
		repeat (3) @(negedge clk);
		low_count(0, n);
		`CHK("upper peak at reset", PER, n)
		low_count(6, n);
		`CHK("lower peak at reset", PER, n)
		$display("test reset done");
	endtask

	// Each upper code is paired with its complement in the lower nibble.
	task automatic t_peak();
		logic [31:0] n;
		logic [3:0]  codes[5] = '{4'h1, 4'h3, 4'h5, 4'h7, 4'hf};
		foreach (codes[i]) begin
			u_host.burst(8'h08, '{{codes[i], ~codes[i]}});
			repeat (3) @(negedge clk);
			low_count(0, n);
			`CHK("upper duty", (codes[i] + 1) * SLT, n)
			low_count(6, n);
			`CHK("lower duty", (16 - codes[i]) * SLT, n)
		end
		$display("test peak done");
	endtask

	// Full blink set-up in one write, the trailing byte landing in the peak register.
	task automatic t_blink();
		logic [31:0] n;
		u_host.burst(8'h10, '{8'h02, 8'h02, 8'h02, 8'h30, 8'h50, 8'h30, 8'h60, 8'h80, 8'h70});
		// The second off time differs, so only the first off phase can last 512 ms.
		while (ph[1] === PH_FADE_ON) @(negedge clk);
		phase_len(PH_ON, n);
		`CHK("fully-on length", 384 * MS, n)
		phase_len(PH_FADE_OFF, n);
		`CHK("fade-off length", 192 * MS, n)
		phase_len(PH_OFF, n);
		`CHK("fully-off length", 512 * MS, n)
		phase_len(PH_FADE_ON, n);
		`CHK("fade-on length", 192 * MS, n)
		while (ph[1] !== PH_ON) @(negedge clk);
		repeat (PER) @(negedge clk);
		low_count(1, n);
		`CHK("peak after second off", PER / 2, n)
		low_count(0, n);
		`CHK("neighbour output dark", 32'd0, n)
		$display("test blink done");
	endtask

	// Reset is held for 20 cycles, then the tests run in order.
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_peak();
		t_blink();
		wrap_up();
	end
endmodule
